// ==== logic/fmr_top.sv ====
// Frame memory reader: burst fetch master, pixel buffer and packet stream output
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: All main logic, stream and slave port included, updates on rising clk only.
// RL2: Reset clears the device; the system releases it in step with clk.
// RL3: Output valid only with pixel data; sink raises ready when it can accept.
// RL4: Start-of-packet marks a frame's first beat, end-of-packet its last.
// RL5: Slave address is a word offset, not a byte address.
// RL6: Slave read strobe returns the addressed register word.
// RL7: Slave write strobe stores write data into the addressed register.
// RL8: Interrupt rises once the interrupt status has been updated; host reads it.
// RL9: Fetch addresses are byte addresses in the memory space.
// RL10: Burst count gives the number of transfers in each read burst.
// RL11: Read strobe issues a request with valid address and burst count.
// RL12: While wait request is high the request is held steady.
// RL13: Read data is taken only in cycles with read data valid.
// RL14: Fetch port runs on its clock edge and has its own reset.
// RL15: Differing fetch clock needs a safe crossing between domains.
module fmr_top
  import fmr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   fetch_port_reset,
  output logic      [FMR_DATA_W-1:0]  dout_data,
  output logic                        dout_valid,
  input  wire logic                   dout_ready,
  output logic                        dout_startofpacket,
  output logic                        dout_endofpacket,
  input  wire logic [FMR_SADDR_W-1:0] slave_address,
  input  wire logic                   slave_read,
  output logic      [FMR_DATA_W-1:0]  slave_readdata,
  input  wire logic                   slave_write,
  input  wire logic [FMR_DATA_W-1:0]  slave_writedata,
  output logic                        host_interrupt,
  output logic      [FMR_ADDR_W-1:0]  master_address,
  output logic      [FMR_BURST_W-1:0] master_burstcount,
  output logic                        master_read,
  input  wire logic                   master_waitrequest,
  input  wire logic [FMR_DATA_W-1:0]  master_readdata,
  input  wire logic                   master_readdatavalid
);
  fmr_cfg_if cfg ();

  fmr_regs u_regs (
    .clk             (clk),
    .rst_b           (rst_b),
    .slave_address   (slave_address),
    .slave_read      (slave_read),
    .slave_readdata  (slave_readdata),
    .slave_write     (slave_write),
    .slave_writedata (slave_writedata),
    .host_interrupt  (host_interrupt),
    .cfg             (cfg)
  );

  // ----------------------------------------
  // Fetch port reset synchroniser
  // ----------------------------------------
  // Fetch port shares clk here, so no data crossing is needed; its reset
  // is still an outside level and passes two flops first. [RL14] [RL15]
  logic fpr_meta;
  logic fpr_sync;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fpr_meta <= 1'b1;
      fpr_sync <= 1'b1;
    end else begin
      fpr_meta <= fetch_port_reset;
      fpr_sync <= fpr_meta;
    end
  end

  logic clr;
  assign clr = !rst_b || fpr_sync; // [RL2] [RL14]

  // ----------------------------------------
  // Frame control state
  // ----------------------------------------
  fmr_state_t             state;
  logic [FMR_WORDS_W-1:0] req_left;
  logic [FMR_WORDS_W-1:0] out_left;
  logic [FMR_CNT_W-1:0]   pending;
  logic [FMR_CNT_W-1:0]   fill;
  logic [FMR_BURST_W-1:0] blen;
  logic [FMR_BURST_W-1:0] next_len;
  logic                   req_taken;
  logic                   beat_out;
  logic                   last_beat;
  logic                   space_ok;
  logic                   fifo_pop;

  // Burst length clamped to 1..max and to what remains of the frame
  always_comb begin
    blen = cfg.burst_len;
    if (blen == '0) begin
      blen = 4'h1;
    end else if (blen > FMR_BURST_MAX) begin
      blen = FMR_BURST_MAX;
    end
    next_len = (req_left < {{(FMR_WORDS_W-FMR_BURST_W){1'b0}}, blen}) ? req_left[FMR_BURST_W-1:0] : blen;
  end

  // Issue only when the whole burst fits: read data cannot be stalled
  assign space_ok  = ({1'b0, fill} + {1'b0, pending} + {2'b00, next_len})
                     <= (FMR_CNT_W+1)'(FMR_FIFO_DEP);
  assign req_taken = master_read && !master_waitrequest;
  assign beat_out  = dout_valid && dout_ready;
  assign last_beat = beat_out && dout_endofpacket;

  always_ff @(posedge clk) begin
    if (clr) begin
      state <= FMR_IDLE;
    end else begin
      unique case (state)
        FMR_IDLE:  if (cfg.run && cfg.frame_words != '0) state <= FMR_FETCH;
        FMR_FETCH: if (req_taken && req_left == {{(FMR_WORDS_W-FMR_BURST_W){1'b0}}, master_burstcount})
                     state <= FMR_FLUSH;
        FMR_FLUSH: if (last_beat) state <= FMR_IDLE;
      endcase
    end
  end

  assign cfg.busy = (state != FMR_IDLE);

  always_ff @(posedge clk) begin
    if (clr) begin
      cfg.frame_done <= 1'b0;
    end else begin
      cfg.frame_done <= last_beat; // [RL8]
    end
  end

  // ----------------------------------------
  // Read master
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (clr) begin
      master_read       <= 1'b0;
      master_address    <= '0;
      master_burstcount <= '0;
      req_left          <= '0;
    end else if (state == FMR_IDLE) begin
      master_read    <= 1'b0;
      master_address <= cfg.base_addr; // [RL9]
      req_left       <= cfg.frame_words;
    end else if (master_read) begin
      if (!master_waitrequest) begin // [RL12]
        master_read    <= 1'b0;
        master_address <= master_address + FMR_BYTES_PER_WORD * {28'h0000000, master_burstcount}; // [RL9]
        req_left       <= req_left - {{(FMR_WORDS_W-FMR_BURST_W){1'b0}}, master_burstcount};
      end
    end else if (state == FMR_FETCH && space_ok) begin
      master_read       <= 1'b1; // [RL11]
      master_burstcount <= next_len; // [RL10]
    end
  end

  // Words asked for but not yet returned
  always_ff @(posedge clk) begin
    if (clr) begin
      pending <= '0;
    end else begin
      pending <= pending + (req_taken ? {1'b0, master_burstcount} : 5'h00)
                         - (master_readdatavalid ? 5'h01 : 5'h00);
    end
  end

  // ----------------------------------------
  // Pixel buffer
  // ----------------------------------------
  logic [FMR_DATA_W-1:0]  mem [FMR_FIFO_DEP];
  logic [FMR_FIFO_AW-1:0] wr_ptr;
  logic [FMR_FIFO_AW-1:0] rd_ptr;

  assign fifo_pop = (fill != '0) && (!dout_valid || dout_ready);

  always_ff @(posedge clk) begin
    if (master_readdatavalid) begin
      mem[wr_ptr] <= master_readdata; // [RL13]
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (master_readdatavalid) begin
        wr_ptr <= wr_ptr + 4'h1; // [RL13]
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      fill <= fill + (master_readdatavalid ? 5'h01 : 5'h00) - (fifo_pop ? 5'h01 : 5'h00);
    end
  end

  // ----------------------------------------
  // Stream output stage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (clr) begin
      dout_valid         <= 1'b0;
      dout_data          <= '0;
      dout_startofpacket <= 1'b0;
      dout_endofpacket   <= 1'b0;
      out_left           <= '0;
    end else begin
      if (state == FMR_IDLE && cfg.run && cfg.frame_words != '0) begin
        out_left <= cfg.frame_words;
      end
      if (fifo_pop) begin
        dout_valid         <= 1'b1; // [RL3] [RL1]
        dout_data          <= mem[rd_ptr];
        dout_startofpacket <= (out_left == cfg.frame_words) && state != FMR_IDLE; // [RL4]
        dout_endofpacket   <= (out_left == 16'h0001); // [RL4]
        out_left           <= out_left - 16'h0001;
      end else if (dout_ready) begin
        dout_valid         <= 1'b0; // [RL3]
        dout_startofpacket <= 1'b0;
        dout_endofpacket   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== inc/fmr_pkg.sv ====
// Package: constants, layout and types of the frame memory reader
`default_nettype none
package fmr_pkg;
  // ----------------------------------------
  // Widths and buffer sizing
  // ----------------------------------------
  localparam int unsigned FMR_DATA_W   = 32;
  localparam int unsigned FMR_ADDR_W   = 32;
  localparam int unsigned FMR_BURST_W  = 4;
  localparam int unsigned FMR_WORDS_W  = 16;
  localparam int unsigned FMR_SADDR_W  = 3;
  localparam int unsigned FMR_FIFO_DEP = 16;
  localparam int unsigned FMR_FIFO_AW  = 4;
  localparam int unsigned FMR_CNT_W    = 5;
  localparam logic [FMR_BURST_W-1:0] FMR_BURST_MAX = 4'h8;
  localparam logic [FMR_ADDR_W-1:0]  FMR_BYTES_PER_WORD = 32'h0000_0004;

  // ----------------------------------------
  // Slave word offsets
  // ----------------------------------------
  localparam logic [FMR_SADDR_W-1:0] FMR_REG_CTRL   = 3'h0;
  localparam logic [FMR_SADDR_W-1:0] FMR_REG_STATUS = 3'h1;
  localparam logic [FMR_SADDR_W-1:0] FMR_REG_IRQ    = 3'h2;
  localparam logic [FMR_SADDR_W-1:0] FMR_REG_BASE   = 3'h3;
  localparam logic [FMR_SADDR_W-1:0] FMR_REG_WORDS  = 3'h4;
  localparam logic [FMR_SADDR_W-1:0] FMR_REG_BURST  = 3'h5;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned FMR_CTRL_RUN_BIT  = 0;
  localparam int unsigned FMR_CTRL_IEN_BIT  = 1;
  localparam int unsigned FMR_STAT_BUSY_BIT = 0;
  localparam int unsigned FMR_IRQ_DONE_BIT  = 0;
  localparam logic [FMR_ADDR_W-1:0]  FMR_BASE_RST  = 32'h0000_0000;
  localparam logic [FMR_WORDS_W-1:0] FMR_WORDS_RST = 16'h0000;
  localparam logic [FMR_BURST_W-1:0] FMR_BURST_RST = 4'h8;

  typedef enum logic [1:0] {
    FMR_IDLE  = 2'b00,
    FMR_FETCH = 2'b01,
    FMR_FLUSH = 2'b11
  } fmr_state_t;
endpackage
`default_nettype wire

// ==== inc/fmr_cfg_if.sv ====
// Interface: configuration and status between register slave and fetch engine
`timescale 1ns/1ps
`default_nettype none
interface fmr_cfg_if;
  import fmr_pkg::*;
  logic                   run;
  logic [FMR_ADDR_W-1:0]  base_addr;
  logic [FMR_WORDS_W-1:0] frame_words;
  logic [FMR_BURST_W-1:0] burst_len;
  logic                   busy;
  logic                   frame_done;

  modport regs   (output run, base_addr, frame_words, burst_len, input busy, frame_done);
  modport engine (input run, base_addr, frame_words, burst_len, output busy, frame_done);
endinterface
`default_nettype wire

// ==== logic/fmr_regs.sv ====
// Register slave of the frame memory reader with its host interrupt
`timescale 1ns/1ps
`default_nettype none
module fmr_regs
  import fmr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic [FMR_SADDR_W-1:0] slave_address,
  input  wire logic                   slave_read,
  output logic      [FMR_DATA_W-1:0]  slave_readdata,
  input  wire logic                   slave_write,
  input  wire logic [FMR_DATA_W-1:0]  slave_writedata,
  output logic                        host_interrupt,
  fmr_cfg_if.regs                     cfg
);
  logic                   run;
  logic                   irq_en;
  logic                   done_flag;
  logic [FMR_ADDR_W-1:0]  base_addr;
  logic [FMR_WORDS_W-1:0] frame_words;
  logic [FMR_BURST_W-1:0] burst_len;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  function automatic logic [FMR_DATA_W-1:0] read_word(input logic [FMR_SADDR_W-1:0] a);
    logic [FMR_DATA_W-1:0] w;
    w = '0;
    unique case (a)
      FMR_REG_CTRL: begin
        w[FMR_CTRL_RUN_BIT] = run;
        w[FMR_CTRL_IEN_BIT] = irq_en;
      end
      FMR_REG_STATUS: w[FMR_STAT_BUSY_BIT] = cfg.busy;
      FMR_REG_IRQ:    w[FMR_IRQ_DONE_BIT]  = done_flag;
      FMR_REG_BASE:   w = base_addr;
      FMR_REG_WORDS:  w[FMR_WORDS_W-1:0] = frame_words;
      FMR_REG_BURST:  w[FMR_BURST_W-1:0] = burst_len;
      default:        w = '0;
    endcase
    return w;
  endfunction

  // Address is a word index, never a byte address [RL5]
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slave_readdata <= '0;
    end else if (slave_read) begin
      slave_readdata <= read_word(slave_address); // [RL6]
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run         <= 1'b0;
      irq_en      <= 1'b0;
      base_addr   <= FMR_BASE_RST;
      frame_words <= FMR_WORDS_RST;
      burst_len   <= FMR_BURST_RST;
    end else if (slave_write) begin
      unique case (slave_address)
        FMR_REG_CTRL: begin
          run    <= slave_writedata[FMR_CTRL_RUN_BIT]; // [RL7]
          irq_en <= slave_writedata[FMR_CTRL_IEN_BIT];
        end
        FMR_REG_BASE:  base_addr   <= slave_writedata;
        FMR_REG_WORDS: frame_words <= slave_writedata[FMR_WORDS_W-1:0];
        FMR_REG_BURST: burst_len   <= slave_writedata[FMR_BURST_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky frame-done flag, write one to clear; a new event beats the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      done_flag <= 1'b0;
    end else if (cfg.frame_done) begin
      done_flag <= 1'b1; // [RL8]
    end else if (slave_write && slave_address == FMR_REG_IRQ && slave_writedata[FMR_IRQ_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_interrupt <= 1'b0;
    end else begin
      host_interrupt <= done_flag & irq_en; // [RL8]
    end
  end

  assign cfg.run         = run;
  assign cfg.base_addr   = base_addr;
  assign cfg.frame_words = frame_words;
  assign cfg.burst_len   = burst_len;
endmodule
`default_nettype wire

// ==== dv/fmr_top_properties.sv ====
// Checker: port-level properties of the frame memory reader
`timescale 1ns/1ps
`default_nettype none
module fmr_top_chk
  import fmr_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   fetch_port_reset,
  input wire logic [FMR_DATA_W-1:0]  dout_data,
  input wire logic                   dout_valid,
  input wire logic                   dout_ready,
  input wire logic                   dout_startofpacket,
  input wire logic                   dout_endofpacket,
  input wire logic [FMR_SADDR_W-1:0] slave_address,
  input wire logic                   slave_read,
  input wire logic [FMR_DATA_W-1:0]  slave_readdata,
  input wire logic                   slave_write,
  input wire logic [FMR_DATA_W-1:0]  slave_writedata,
  input wire logic                   host_interrupt,
  input wire logic [FMR_ADDR_W-1:0]  master_address,
  input wire logic [FMR_BURST_W-1:0] master_burstcount,
  input wire logic                   master_read,
  input wire logic                   master_waitrequest,
  input wire logic [FMR_DATA_W-1:0]  master_readdata,
  input wire logic                   master_readdatavalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic       xfer;
  logic       eop_x;
  logic       in_pkt;
  logic [5:0] held;
  assign xfer  = dout_valid && dout_ready;
  assign eop_x = xfer && dout_endofpacket;
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) in_pkt <= 1'b0;
    else if (xfer) in_pkt <= !dout_endofpacket;
  end
  // Words fetched but not yet handed to the sink
  always_ff @(posedge clk) begin
    if (!rst_b) held <= 6'h00;
    else held <= held + {5'h00, master_readdatavalid} - {5'h00, xfer};
  end
  AST_REQ_HOLD: assert property (master_read && master_waitrequest |=> master_read &&
    $stable(master_address) && $stable(master_burstcount)) else $error("request moved while stalled");
  AST_REQ_GAP: assert property (master_read && !master_waitrequest |=> !master_read)
    else $error("read held after acceptance");
  AST_BURST: assert property (master_read |-> master_burstcount inside {[4'h1:FMR_BURST_MAX]})
    else $error("burst count out of range");
  AST_ALIGN: assert property (master_read |-> master_address[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  AST_OUT_HOLD: assert property (dout_valid && !dout_ready |=> dout_valid &&
    $stable(dout_data) && $stable(dout_endofpacket)) else $error("beat changed before acceptance");
  AST_VALID_DATA: assert property (dout_valid |-> held != 6'h00)
    else $error("valid without fetched data");
  AST_SOP: assert property (dout_valid |-> dout_startofpacket == !in_pkt)
    else $error("start marker misplaced");
  AST_IRQ_CAUSE: assert property ($rose(host_interrupt) |-> $past(eop_x, 3) || $past(slave_write))
    else $error("interrupt without cause");
  AST_RAW: assert property (slave_write && slave_address == FMR_REG_BASE ##1
    slave_read && slave_address == FMR_REG_BASE |=> slave_readdata == $past(slave_writedata, 2))
    else $error("read back differs from write");
  AST_UNMAPPED: assert property (slave_read && slave_address == 3'h7 |=> slave_readdata == 32'h0)
    else $error("unmapped offset not zero");
  AST_RST_IDLE: assert property ($rose(rst_b) |-> !dout_valid && !master_read && !host_interrupt)
    else $error("outputs active after reset");
  COV_STALL: cover property (master_read && master_waitrequest);
  COV_BACKPR: cover property (dout_valid && !dout_ready);
  COV_IRQ: cover property ($rose(host_interrupt));
endmodule
bind fmr_top fmr_top_chk chk_u (.clk(clk), .rst_b(rst_b), .fetch_port_reset(fetch_port_reset),
  .dout_data(dout_data), .dout_valid(dout_valid), .dout_ready(dout_ready),
  .dout_startofpacket(dout_startofpacket), .dout_endofpacket(dout_endofpacket),
  .slave_address(slave_address), .slave_read(slave_read), .slave_readdata(slave_readdata),
  .slave_write(slave_write), .slave_writedata(slave_writedata), .host_interrupt(host_interrupt),
  .master_address(master_address), .master_burstcount(master_burstcount), .master_read(master_read),
  .master_waitrequest(master_waitrequest), .master_readdata(master_readdata),
  .master_readdatavalid(master_readdatavalid));
`default_nettype wire

// ==== dv/fmr_mem_model.sv ====
// Memory fabric model answering the fetch master's bursts
`timescale 1ns/1ps
`default_nettype none
module fmr_mem_model
  import fmr_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   slow,
  input  wire logic [FMR_ADDR_W-1:0]  master_address,
  input  wire logic [FMR_BURST_W-1:0] master_burstcount,
  input  wire logic                   master_read,
  output logic                        master_waitrequest,
  output logic      [FMR_DATA_W-1:0]  master_readdata,
  output logic                        master_readdatavalid
);
  logic [FMR_ADDR_W-1:0] q[$];
  logic [FMR_ADDR_W-1:0] a;
  logic [1:0]            ph;
  // ----------------------------------------
  // Request capture and return
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      q.delete();
      ph <= 2'h0;
      master_waitrequest <= 1'b0;
      master_readdatavalid <= 1'b0;
      master_readdata <= 32'h0;
    end else begin
      ph <= ph + 2'h1;
      if (master_read && !master_waitrequest)
        for (int i = 0; i < master_burstcount; i++) q.push_back(master_address + 32'(4 * i));
      master_waitrequest <= slow && ph != 2'h3;
      // Slow mode also spaces the returned words
      if (q.size() != 0 && !(slow && ph[0])) begin
        a = q.pop_front();
        master_readdatavalid <= 1'b1;
        master_readdata <= {a[15:0], ~a[15:0]};
      end else begin
        master_readdatavalid <= 1'b0;
        master_readdata <= ~master_readdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_frame_memory_reader.sv ====
// Testbench: self-checking bench of the frame memory reader
`timescale 1ns/1ps
`default_nettype none
module tb_frame_memory_reader;
  import fmr_pkg::*;
  typedef struct packed {logic [31:0] base; logic [15:0] words; logic [3:0] burst; logic slow; logic bp;} fmr_row_t;
  localparam fmr_row_t ROWS [4] = '{'{32'h0000_1000, 16'h0001, 4'h1, 1'b0, 1'b0},
    '{32'h0000_2000, 16'h0005, 4'h0, 1'b0, 1'b1}, '{32'h0000_3000, 16'h0014, 4'h8, 1'b1, 1'b1},
    '{32'h0000_4000, 16'h0009, 4'hF, 1'b1, 1'b0}};
  logic clk, rst_b, fetch_port_reset, dout_valid, dout_ready, dout_startofpacket, dout_endofpacket;
  logic slave_read, slave_write, host_interrupt, master_read, master_waitrequest, master_readdatavalid, slow, bp;
  logic [31:0] dout_data, slave_readdata, slave_writedata, master_address, master_readdata, base, rd_v;
  logic [2:0]  slave_address;
  logic [3:0]  master_burstcount, eb;
  logic [15:0] words;
  int          n_errors, checks_done, cyc, beat, iss, bc, k;
  fmr_top dut_u (.clk(clk), .rst_b(rst_b), .fetch_port_reset(fetch_port_reset), .dout_data(dout_data),
    .dout_valid(dout_valid), .dout_ready(dout_ready), .dout_startofpacket(dout_startofpacket),
    .dout_endofpacket(dout_endofpacket), .slave_address(slave_address), .slave_read(slave_read),
    .slave_readdata(slave_readdata), .slave_write(slave_write), .slave_writedata(slave_writedata),
    .host_interrupt(host_interrupt), .master_address(master_address), .master_burstcount(master_burstcount),
    .master_read(master_read), .master_waitrequest(master_waitrequest), .master_readdata(master_readdata),
    .master_readdatavalid(master_readdatavalid));
  fmr_mem_model mem_u (.clk(clk), .rst_b(rst_b), .slow(slow), .master_address(master_address),
    .master_burstcount(master_burstcount), .master_read(master_read), .master_waitrequest(master_waitrequest),
    .master_readdata(master_readdata), .master_readdatavalid(master_readdatavalid));
  // ----------------------------------------
  // Helpers, monitors and sequence
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    // Idle edge first, so a strobe lowered by the last call is not raised again at once
    @(negedge clk);
    slave_address = a;
    slave_writedata = d;
    slave_write = 1'b1;
    @(negedge clk);
    slave_write = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    slave_address = a;
    slave_read = 1'b1;
    @(negedge clk);
    slave_read = 1'b0;
    d = slave_readdata;
    @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  always @(posedge clk) begin
    if (rst_b && dout_valid && dout_ready) begin
      chk("dout_data", {base[15:0] + 16'(beat * 4), ~(base[15:0] + 16'(beat * 4))}, dout_data);
      chk("sop", {31'h0, beat == 0}, {31'h0, dout_startofpacket});
      chk("eop", {31'h0, beat == words - 1}, {31'h0, dout_endofpacket});
      beat++;
    end
    if (rst_b && master_read && !master_waitrequest) begin
      bc = (words - iss) < eb ? words - iss : eb;
      chk("master_address", base + 32'(iss * 4), master_address);
      chk("master_burstcount", 32'(bc), {28'h0, master_burstcount});
      iss += bc;
    end
  end
  initial begin
    {slave_read, slave_write, fetch_port_reset, dout_ready, slow, bp} = '0;
    slave_address = 3'h0;
    slave_writedata = 32'h0;
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    foreach (ROWS[r]) begin
      {base, words, slow, bp} = {ROWS[r].base, ROWS[r].words, ROWS[r].slow, ROWS[r].bp};
      eb = ROWS[r].burst == 4'h0 ? 4'h1 : (ROWS[r].burst > 4'h8 ? 4'h8 : ROWS[r].burst);
      beat = 0;
      iss = 0;
      wr(FMR_REG_BASE, base);
      rd(FMR_REG_BASE, rd_v);
      chk("base", base, rd_v);
      wr(FMR_REG_WORDS, {16'h0, words});
      wr(FMR_REG_BURST, {28'h0, ROWS[r].burst});
      wr(FMR_REG_CTRL, 32'h3);
      for (k = 0; k < 300 && dout_valid !== 1'b1; k++) @(negedge clk);
      rd(FMR_REG_STATUS, rd_v);
      chk("busy", 32'h1, rd_v);
      // Sink stays stalled until run is cleared, so only one frame goes out
      wr(FMR_REG_CTRL, 32'h2);
      for (k = 0; k < 2000 && beat < words; k++) begin
        dout_ready = bp ? ~dout_ready : 1'b1;
        @(negedge clk);
      end
      dout_ready = 1'b0;
      chk("beats", 32'(words), 32'(beat));
      for (k = 0; k < 10 && host_interrupt !== 1'b1; k++) @(negedge clk);
      chk("host_interrupt", 32'h1, {31'h0, host_interrupt});
      rd(FMR_REG_IRQ, rd_v);
      chk("irq_status", 32'h1, {31'h0, rd_v[FMR_IRQ_DONE_BIT]});
      wr(FMR_REG_IRQ, 32'h1);
      repeat (2) @(negedge clk);
      chk("irq_cleared", 32'h0, {31'h0, host_interrupt});
    end
    {base, words, eb, beat, iss} = {32'h0000_5000, 16'h0010, 4'h8, 32'h0, 32'h0};
    wr(FMR_REG_BASE, base);
    wr(FMR_REG_WORDS, {16'h0, words});
    wr(FMR_REG_CTRL, 32'h3);
    for (k = 0; k < 300 && dout_valid !== 1'b1; k++) @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk("valid_after_reset", 32'h0, {31'h0, dout_valid});
    chk("read_after_reset", 32'h0, {31'h0, master_read});
    rd(FMR_REG_BURST, rd_v);
    chk("burst_reset", {28'h0, FMR_BURST_RST}, rd_v);
    rd(FMR_REG_BASE, rd_v);
    chk("base_reset", FMR_BASE_RST, rd_v);
    rd(3'h7, rd_v);
    chk("unmapped", 32'h0, rd_v);
    wr(FMR_REG_STATUS, 32'hFFFF_FFFF);
    rd(FMR_REG_STATUS, rd_v);
    chk("status_ro", 32'h0, rd_v);
    wr(FMR_REG_BASE, 32'h0000_6000);
    fetch_port_reset = 1'b1;
    repeat (3) @(negedge clk);
    fetch_port_reset = 1'b0;
    rd(FMR_REG_BASE, rd_v);
    chk("base_kept", 32'h0000_6000, rd_v);
    // Frame with the interrupt enable off: status sets, pin stays low
    {base, words, beat, iss} = {32'h0000_6000, 16'h0001, 32'h0, 32'h0};
    wr(FMR_REG_WORDS, {16'h0, words});
    wr(FMR_REG_CTRL, 32'h1);
    for (k = 0; k < 300 && dout_valid !== 1'b1; k++) @(negedge clk);
    wr(FMR_REG_CTRL, 32'h0);
    dout_ready = 1'b1;
    repeat (8) @(negedge clk);
    chk("beats_masked", 32'h1, 32'(beat));
    chk("irq_masked", 32'h0, {31'h0, host_interrupt});
    rd(FMR_REG_IRQ, rd_v);
    chk("irq_status_masked", 32'h1, {31'h0, rd_v[FMR_IRQ_DONE_BIT]});
    give_verdict();
  end
endmodule
`default_nettype wire
